// file: shared/phy_irq_pkg.sv
// Package: register map, field positions and reset values of the interrupt block.
// Assumes word-aligned AHB-Lite access; register indices are the printed offsets.
package phy_irq_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IRQ_CTRL_IDX     = 8'h11;
  localparam logic [7:0] IRQ_STAT_IDX     = 8'h12;
  localparam logic [7:0] IRQ_SRC_IDX      = 8'h13;
  localparam logic [9:0] IRQ_CTRL_ADDR    = {IRQ_CTRL_IDX, 2'b00};
  localparam logic [9:0] IRQ_STAT_ADDR    = {IRQ_STAT_IDX, 2'b00};
  localparam logic [9:0] IRQ_SRC_ADDR     = {IRQ_SRC_IDX, 2'b00};
  localparam int         ADDR_W           = 10;
  // Control register fields
  localparam int         CTRL_OE_BIT      = 0;
  localparam int         CTRL_GEN_BIT     = 1;
  localparam int         CTRL_TEST_BIT    = 2;
  localparam int         CTRL_ROUTE_BIT   = 3;
  localparam logic [3:0] CTRL_RESET       = 4'h0;
  // Source register fields: counter select, summary pending, time-sync remaining
  localparam int         SRC_CSEL_LO      = 0;
  localparam int         SRC_PEND_BIT     = 8;
  localparam int         SRC_TSYNC_BIT    = 9;
  localparam logic [1:0] CSEL_RESET       = 2'h0;
  // Status register layout
  localparam int         NUM_FLAGS        = 8;
  localparam int         FLAG_LO          = 8;
  localparam int         EN_W             = 8;
  localparam logic [7:0] EN_RESET         = 8'h00;
  localparam logic [7:0] FLAG_RESET       = 8'h00;
  // Flag indices within the upper byte
  localparam int         F_CNT_LO         = 0;
  localparam int         F_CNT_HI         = 1;
  localparam int         F_ANEG           = 2;
  localparam int         F_DUP_TS         = 3;
  localparam int         F_SPEED          = 4;
  localparam int         F_LINK           = 5;
  localparam int         F_ENERGY         = 6;
  localparam int         F_LQ             = 7;
  // Event input indices
  localparam int         EV_LQ            = 0;
  localparam int         EV_ENERGY        = 1;
  localparam int         EV_LINK          = 2;
  localparam int         EV_SPEED         = 3;
  localparam int         EV_DUPLEX        = 4;
  localparam int         EV_TSYNC         = 5;
  localparam int         EV_ANEG          = 6;
  localparam int         EV_FCAR_HF       = 7;
  localparam int         EV_RXERR_HF      = 8;
  localparam int         EV_CTRL_FRAME    = 9;
  localparam int         NUM_EVENTS       = 10;
  localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
endpackage

// file: logic/irq_flag_bank.sv
// Bank of sticky event flags cleared on read.
// Assumes event pulses and the clear strobe share the module clock.
`timescale 1ns/1ps
module irq_flag_bank
  import phy_irq_pkg::*;
#(
  parameter int N = NUM_FLAGS
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [N-1:0] i_set,
  input  wire logic [N-1:0] i_clear,
  output logic      [N-1:0] o_flags
);
  logic [N-1:0] flag_q;
  logic [N-1:0] flag_d;

  // Set wins over clear so a same-cycle event stays for the next read
  always_comb begin
    flag_d = (flag_q & ~i_clear) | i_set; // RULE19
  end

  // ****************
  // Flag registers
  // ****************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flags = flag_q;
endmodule

// file: logic/phy_interrupt_ctrl_status.sv
// Interrupt control and status for the transceiver: AHB-Lite slave, latched
// event flags, gating and the shared power-down/interrupt pin.
// Assumes event inputs are one-cycle pulses in the i_ref_clk domain; the pin
// input comes from outside and is synchronised here.
//
// Summary of operation
// RULE1: Control upper bits ignore writes, read zero
// RULE2: Route select moves time-sync and speed/duplex flags
// RULE3: Test-force bit holds interrupt asserted
// RULE4: Global enable gates all event interrupts
// RULE5: Output-enable bit makes pin interrupt output
// RULE6: Status flag sets on event since last read
// RULE7: Interrupt needs per-event enable and global permit
// RULE8: Flags latch regardless of enables
// RULE9: Bit 15 link-quality flag, clear on read
// RULE10: Bit 14 energy-detect flag, clear on read
// RULE11: Bit 13 link-change flag, clear on read
// RULE12: Bit 12 speed or speed/duplex, clear on read
// RULE13: Bit 11 duplex change when route zero
// RULE14: Time-sync flag rearms only when none remain
// RULE15: Bits 9,8 counter flags per select field
// RULE16: Low bits are read-write per-event enables
// RULE17: Summary pending bit cleared by status read
// RULE18: Pin driven low while enabled flag pending
// RULE19: Event during clearing read stays latched
// RULE20: Host reads status after each interrupt
`timescale 1ns/1ps
module phy_interrupt_ctrl_status
  import phy_irq_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  // AHB-Lite slave
  input  wire logic                  i_hsel,
  input  wire logic [31:0]           i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic [2:0]            i_hsize,
  input  wire logic [31:0]           i_hwdata,
  input  wire logic                  i_hready,
  output logic      [31:0]           o_hrdata,
  output logic                       o_hreadyout,
  output logic                       o_hresp,
  // Event pulses from the detectors
  input  wire logic [NUM_EVENTS-1:0] i_events,
  // Time-sync unit still holds status
  input  wire logic                  i_timesync_status_avail,
  // Shared power-down/interrupt pin, three signals
  input  wire logic                  i_powerdown_or_irq_pin,
  output logic                       o_powerdown_or_irq_pin,
  output logic                       o_powerdown_or_irq_pin_oe,
  // Power-down request seen on the pin in input mode
  output logic                       o_powerdown_req
);

  // ****************
  // Bus front end
  // ****************
  logic              wr_pend_q, wr_pend_d;
  logic              rd_take;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              addr_phase;

  // Single-word transfers only; other sizes are still answered OKAY
  // Size is not decoded, so a narrow write lands as a whole word
  assign addr_phase = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);

  always_comb begin
    wr_pend_d = addr_phase && i_hwrite;
    addr_d    = addr_phase ? i_haddr[ADDR_W-1:0] : addr_q;
  end

  // Reads need no pending state: data and clear both act at the address edge
  assign rd_take = addr_phase && !i_hwrite;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      addr_q    <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ****************
  // Control and configuration
  // ****************
  logic [3:0]       ctrl_q, ctrl_d;
  logic [EN_W-1:0]  en_q, en_d;
  logic [1:0]       csel_q, csel_d;
  logic             wr_ctrl, wr_stat, wr_src;

  // Register decode, shared by the write strobes and the clear strobe
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] target);
    addr_hit = (a == target);
  endfunction

  assign wr_ctrl = wr_pend_q && addr_hit(addr_q, IRQ_CTRL_ADDR);
  assign wr_stat = wr_pend_q && addr_hit(addr_q, IRQ_STAT_ADDR);
  assign wr_src  = wr_pend_q && addr_hit(addr_q, IRQ_SRC_ADDR);

  // Only the defined low bits are stored; upper bits are dropped
  always_comb begin
    ctrl_d = wr_ctrl ? i_hwdata[3:0] : ctrl_q; // RULE1
    en_d   = wr_stat ? i_hwdata[EN_W-1:0] : en_q; // RULE16
    csel_d = wr_src ? i_hwdata[SRC_CSEL_LO+:2] : csel_q;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RESET;
      en_q   <= EN_RESET;
      csel_q <= CSEL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      en_q   <= en_d;
      csel_q <= csel_d;
    end
  end

  logic route_sel, test_force, gen_en, pin_oe;
  assign pin_oe     = ctrl_q[CTRL_OE_BIT];
  assign gen_en     = ctrl_q[CTRL_GEN_BIT];
  assign test_force = ctrl_q[CTRL_TEST_BIT];
  assign route_sel  = ctrl_q[CTRL_ROUTE_BIT];

  // ****************
  // Event routing
  // ****************
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic                 ts_armed_q, ts_armed_d;
  logic                 ts_fire;
  logic                 cnt_combined;
  logic                 rd_stat;

  // Clear at the edge that captures the read data; an event sampled at that
  // edge sets its flag after the capture and set wins, so none is lost
  assign rd_stat      = rd_take && addr_hit(i_haddr[ADDR_W-1:0], IRQ_STAT_ADDR); // RULE19
  assign cnt_combined = |csel_q;

  // Time-sync event fires once, then waits for the unit to drain its status
  // Limitation: an event that arrives while disarmed is dropped, not queued
  assign ts_fire = i_events[EV_TSYNC] && ts_armed_q;
  always_comb begin
    ts_armed_d = ts_armed_q;
    if (ts_fire) begin
      ts_armed_d = 1'b0; // RULE14
    end else if (!ts_armed_q && !i_timesync_status_avail) begin
      ts_armed_d = 1'b1; // RULE14
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ts_armed_q <= 1'b1;
    end else begin
      ts_armed_q <= ts_armed_d;
    end
  end

  // Routing follows the selects; flags set whatever the enables say
  always_comb begin
    flag_set           = '0;
    flag_set[F_LQ]     = i_events[EV_LQ]; // RULE9
    flag_set[F_ENERGY] = i_events[EV_ENERGY]; // RULE10
    flag_set[F_LINK]   = i_events[EV_LINK]; // RULE11
    flag_set[F_ANEG]   = i_events[EV_ANEG];
    if (route_sel) begin
      flag_set[F_SPEED]  = i_events[EV_SPEED] | i_events[EV_DUPLEX]; // RULE2 RULE12
      flag_set[F_DUP_TS] = ts_fire; // RULE2
    end else begin
      flag_set[F_SPEED]  = i_events[EV_SPEED]; // RULE12
      flag_set[F_DUP_TS] = i_events[EV_DUPLEX]; // RULE13
    end
    if (cnt_combined) begin
      flag_set[F_CNT_HI] = i_events[EV_FCAR_HF] | i_events[EV_RXERR_HF]; // RULE15
      flag_set[F_CNT_LO] = i_events[EV_CTRL_FRAME]; // RULE15
    end else begin
      flag_set[F_CNT_HI] = i_events[EV_FCAR_HF]; // RULE15
      flag_set[F_CNT_LO] = i_events[EV_RXERR_HF]; // RULE15
    end
  end

  // Read of the status register clears every flag it returned
  assign flag_clr = {NUM_FLAGS{rd_stat}};

  irq_flag_bank #(
    .N (NUM_FLAGS)
  ) u_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_set     (flag_set), // RULE6 RULE8
    .i_clear   (flag_clr), // RULE9 RULE10 RULE11 RULE12 RULE13
    .o_flags   (flags)
  );

  // ****************
  // Interrupt generation and summary
  // ****************
  logic [NUM_FLAGS-1:0] en_map;
  logic                 irq_active;
  logic                 pend_q, pend_d;

  // Enable bit k of the low byte pairs with flag k
  assign en_map = en_q;

  // Test force bypasses the global enable so handlers can be exercised
  assign irq_active = (gen_en && |(flags & en_map)) || test_force; // RULE3 RULE4 RULE7

  // Summary tracks pending interrupt; status read clears it, new event wins
  always_comb begin
    pend_d = pend_q;
    if (rd_stat) begin
      pend_d = 1'b0; // RULE17
    end
    if (gen_en && |(flag_set & en_map)) begin
      pend_d = 1'b1; // RULE17
    end
    if (test_force) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // ****************
  // Shared pin
  // ****************
  logic pin_meta_q, pin_sync_q;
  logic pin_out_q, pin_out_d;
  logic pin_oe_q, pin_oe_d;

  // Registered drive keeps the pin free of decode glitches
  always_comb begin
    pin_oe_d  = pin_oe; // RULE5
    pin_out_d = !irq_active; // RULE18
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_out_q  <= 1'b1;
      pin_oe_q   <= 1'b0;
    end else begin
      pin_meta_q <= i_powerdown_or_irq_pin;
      pin_sync_q <= pin_meta_q;
      pin_out_q  <= pin_out_d;
      pin_oe_q   <= pin_oe_d;
    end
  end

  assign o_powerdown_or_irq_pin    = pin_out_q;
  assign o_powerdown_or_irq_pin_oe = pin_oe_q;
  // Pin low as input means power down; ignored while we drive it
  assign o_powerdown_req = !pin_oe_q && !pin_sync_q; // RULE5

  // ****************
  // Read data
  // ****************
  always_comb begin
    rdata_d = '0;
    if (rd_take) begin
      case (i_haddr[ADDR_W-1:0])
        IRQ_CTRL_ADDR: rdata_d[3:0] = ctrl_q; // RULE1
        IRQ_STAT_ADDR: rdata_d[15:0] = {flags, en_q};
        IRQ_SRC_ADDR: begin
          rdata_d[SRC_CSEL_LO+:2] = csel_q;
          rdata_d[SRC_PEND_BIT]   = pend_q;
          rdata_d[SRC_TSYNC_BIT]  = i_timesync_status_avail;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Flags captured and cleared at the address edge; data stands one cycle
  // in the data phase, and an event at the capture edge waits for the next
  // read because set wins over clear in the flag bank
  assign o_hrdata = rdata_q;
endmodule

// file: test/phy_irq_asserts.sv
// Checker: bus answer, flag latching and pin relations at the block's ports.
// Assumes single-word AHB-Lite transfers; control writes are shadowed here.
`timescale 1ns/1ps
module phy_irq_asserts
  import phy_irq_pkg::*;
(
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst,
  input wire logic                  i_hsel,
  input wire logic [31:0]           i_haddr,
  input wire logic [1:0]            i_htrans,
  input wire logic                  i_hwrite,
  input wire logic [31:0]           i_hwdata,
  input wire logic                  i_hready,
  input wire logic [31:0]           o_hrdata,
  input wire logic                  o_hreadyout,
  input wire logic                  o_hresp,
  input wire logic [NUM_EVENTS-1:0] i_events,
  input wire logic                  i_powerdown_or_irq_pin,
  input wire logic                  o_powerdown_or_irq_pin,
  input wire logic                  o_powerdown_or_irq_pin_oe,
  input wire logic                  o_powerdown_req
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic       take, rd, rd_st, ev_lq, wr_c_q;
  logic [3:0] ctrl_q;
  // Transfer taken at an address edge
  assign take  = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  assign rd    = take && !i_hwrite;
  assign rd_st = rd && i_haddr[9:0] == IRQ_STAT_ADDR;
  assign ev_lq = i_events[EV_LQ];
  // Shadow lands at the data edge, same moment as the real register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_c_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
    end else begin
      wr_c_q <= take && i_hwrite && i_haddr[9:0] == IRQ_CTRL_ADDR;
      if (wr_c_q) ctrl_q <= i_hwdata[3:0];
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ****************************************
  // Assertions
  // ****************************************
  chk_bus_okay: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1)
    else $error("bus answer not ready and OKAY");
  chk_rdata_idle: assert property (!rd |=> o_hrdata == 32'h0)
    else $error("read data outside a read data phase");
  chk_ctrl_upper: assert property (rd && i_haddr[9:0] == IRQ_CTRL_ADDR |=> o_hrdata[31:4] == 28'h0)
    else $error("control upper bits not zero");
  chk_lq_latch: assert property ((ev_lq && !rd_st) ##1 !rd_st ##1 rd_st |=> o_hrdata[15])
    else $error("link quality event not latched");
  chk_lq_clear: assert property ((rd_st && !ev_lq) ##1 (o_hrdata[15] && !ev_lq) ##1 (rd_st && !ev_lq)
    |=> !o_hrdata[15])
    else $error("link quality flag survived its read");
  chk_test_force: assert property (ctrl_q[CTRL_TEST_BIT] [*2] |-> !o_powerdown_or_irq_pin)
    else $error("test force did not assert pin");
  chk_no_source: assert property ((!ctrl_q[CTRL_GEN_BIT] && !ctrl_q[CTRL_TEST_BIT]) [*2]
    |-> o_powerdown_or_irq_pin)
    else $error("pin asserted with events disabled");
  chk_oe_follow: assert property ($stable(ctrl_q[CTRL_OE_BIT]) [*2]
    |-> o_powerdown_or_irq_pin_oe == ctrl_q[CTRL_OE_BIT])
    else $error("pin enable differs from control");
  chk_pd_idle: assert property (i_powerdown_or_irq_pin [*4] |-> !o_powerdown_req)
    else $error("power-down with pin high");
  chk_pd_output: assert property (o_powerdown_or_irq_pin_oe [*2] |-> !o_powerdown_req)
    else $error("power-down while pin is output");
endmodule

// file: test/host_pin_model.sv
// Host side of the shared power-down/interrupt line.
// Assumes the bench asks for power-down only while the device pin is an input.
`timescale 1ns/1ps
module host_pin_model (
  input  wire logic i_irq_level,
  input  wire logic i_irq_oe,
  input  wire logic i_pd_low,
  output logic      o_pin_level
);
  // Pull-up holds the line high when nobody drives it; host never fights the device
  assign o_pin_level = i_irq_oe ? i_irq_level : !i_pd_low;
endmodule

// file: test/phy_interrupt_ctrl_status_bench.sv
// Bench: drives the interrupt block over AHB-Lite, event pulses and the shared pin.
// Assumes a zero-wait slave; host pin model on the far side.
`timescale 1ns/1ps
module phy_interrupt_ctrl_status_bench;
  import phy_irq_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic                  i_ref_clk, i_rst, i_hsel, i_hwrite, i_timesync_status_avail, pd_low;
  logic [31:0]           i_haddr, i_hwdata, o_hrdata;
  logic [1:0]            i_htrans;
  logic [2:0]            i_hsize;
  logic [NUM_EVENTS-1:0] i_events;
  logic                  o_hreadyout, o_hresp, i_powerdown_or_irq_pin, o_powerdown_or_irq_pin;
  logic                  o_powerdown_or_irq_pin_oe, o_powerdown_req;
  int                    fails, num_checks;
  int                    ev_tab [8] = '{EV_LQ, EV_ENERGY, EV_LINK, EV_SPEED, EV_DUPLEX, EV_ANEG, EV_FCAR_HF, EV_RXERR_HF};
  phy_interrupt_ctrl_status uut (.i_ref_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_events, .i_timesync_status_avail,
    .i_powerdown_or_irq_pin, .o_powerdown_or_irq_pin, .o_powerdown_or_irq_pin_oe, .o_powerdown_req);
  host_pin_model host (.i_irq_level(o_powerdown_or_irq_pin), .i_irq_oe(o_powerdown_or_irq_pin_oe),
    .i_pd_low(pd_low), .o_pin_level(i_powerdown_or_irq_pin));
  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [NUM_EVENTS-1:0] ev1(input int k);
    ev1 = '0;
    ev1[k] = 1'b1;
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One transfer; events e ride the address phase; master waits on hready, no fixed count
  task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] wd,
                     input logic [NUM_EVENTS-1:0] e, output logic [31:0] rdv);
    i_hsel <= 1'b1;
    i_haddr <= {22'h0, a};
    i_htrans <= HTRANS_NONSEQ;
    i_hwrite <= w;
    if (e != '0) i_events <= e;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    if (e != '0) i_events <= '0;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    rdv = o_hrdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, '0, r);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, '0, r);
    cmp(what, exp, r);
  endtask
  task automatic pulse(input int k);
    i_events <= ev1(k);
    @(posedge i_ref_clk);
    i_events <= '0;
    @(posedge i_ref_clk);
  endtask
  task automatic pin(input logic exp);
    repeat (3) @(posedge i_ref_clk);
    cmp("pin", {31'h0, exp}, {31'h0, o_powerdown_or_irq_pin});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(IRQ_CTRL_ADDR, 32'h0, "ctrl reset");
    rd(IRQ_STAT_ADDR, 32'h0, "status reset");
    rd(10'h3F0, 32'h0, "unmapped");
    cmp("oe reset", 32'h0, {31'h0, o_powerdown_or_irq_pin_oe});
  endtask
  task automatic t_ctrl;
    wr(IRQ_CTRL_ADDR, 32'hFFFFFFF0);
    rd(IRQ_CTRL_ADDR, 32'h0, "ctrl upper");
    wr(IRQ_CTRL_ADDR, 32'hA);
    rd(IRQ_CTRL_ADDR, 32'hA, "ctrl low");
    wr(IRQ_STAT_ADDR, 32'hFFFF);
    rd(IRQ_STAT_ADDR, 32'hFF, "enables rw");
    wr(IRQ_STAT_ADDR, 32'h0);
    wr(IRQ_CTRL_ADDR, 32'h0);
  endtask
  // Each source except time-sync and control-frame lands on its own bit with every enable off
  task automatic t_flags;
    for (int i = 0; i < 8; i++) begin
      pulse(ev_tab[i]);
      rd(IRQ_STAT_ADDR, 32'h8000 >> i, "flag set");
      rd(IRQ_STAT_ADDR, 32'h0, "flag cleared");
    end
  endtask
  task automatic t_route;
    wr(IRQ_CTRL_ADDR, 32'h8);
    i_timesync_status_avail <= 1'b1;
    pulse(EV_DUPLEX);
    rd(IRQ_STAT_ADDR, 32'h1000, "dup to speed");
    pulse(EV_TSYNC);
    rd(IRQ_STAT_ADDR, 32'h0800, "tsync");
    pulse(EV_TSYNC);
    rd(IRQ_STAT_ADDR, 32'h0, "tsync no rearm");
    i_timesync_status_avail <= 1'b0;
    @(posedge i_ref_clk);
    pulse(EV_TSYNC);
    rd(IRQ_STAT_ADDR, 32'h0800, "tsync rearm");
    wr(IRQ_CTRL_ADDR, 32'h0);
  endtask
  task automatic t_csel;
    wr(IRQ_SRC_ADDR, 32'h1);
    rd(IRQ_SRC_ADDR, 32'h1, "csel rw");
    pulse(EV_RXERR_HF);
    rd(IRQ_STAT_ADDR, 32'h0200, "combined cnt");
    pulse(EV_CTRL_FRAME);
    rd(IRQ_STAT_ADDR, 32'h0100, "ctrl frame");
    wr(IRQ_SRC_ADDR, 32'h0);
  endtask
  task automatic t_gate;
    logic [31:0] r;
    wr(IRQ_CTRL_ADDR, 32'h1);
    wr(IRQ_STAT_ADDR, 32'h80);
    pulse(EV_LQ);
    pin(1'b1);
    rd(IRQ_STAT_ADDR, 32'h8080, "polled flag");
    wr(IRQ_CTRL_ADDR, 32'h3);
    pulse(EV_ENERGY);
    pin(1'b1);
    rd(IRQ_STAT_ADDR, 32'h4080, "masked flag");
    pulse(EV_LQ);
    pin(1'b0);
    rd(IRQ_SRC_ADDR, 32'h100, "pending set");
    rd(IRQ_STAT_ADDR, 32'h8080, "irq source");
    pin(1'b1);
    rd(IRQ_SRC_ADDR, 32'h0, "pending clear");
    bus(IRQ_STAT_ADDR, 1'b0, 32'h0, ev1(EV_LQ), r);
    cmp("read with event", 32'h80, r);
    rd(IRQ_STAT_ADDR, 32'h8080, "event kept");
  endtask
  task automatic t_test;
    wr(IRQ_CTRL_ADDR, 32'h5);
    pin(1'b0);
    cmp("oe out", 32'h1, {31'h0, o_powerdown_or_irq_pin_oe});
    wr(IRQ_CTRL_ADDR, 32'h1);
    pin(1'b1);
  endtask
  task automatic t_pd;
    wr(IRQ_CTRL_ADDR, 32'h0);
    pd_low <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    cmp("pd req", 32'h1, {31'h0, o_powerdown_req});
    pd_low <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    cmp("pd idle", 32'h0, {31'h0, o_powerdown_req});
  endtask
  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_rst, i_hsel, i_hwrite, i_timesync_status_avail, pd_low} = 5'h10;
    {i_haddr, i_hwdata, i_htrans, i_hsize, i_events} = {64'h0, 2'h0, 3'h2, 10'h0};
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    t_reset();
    t_ctrl();
    t_flags();
    t_route();
    t_csel();
    t_gate();
    t_test();
    t_pd();
    summarize();
  end
  // Whole run is well under a thousand cycles; this cuts a hung handshake short
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule
bind phy_interrupt_ctrl_status phy_irq_asserts chk (.i_ref_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_events, .i_powerdown_or_irq_pin,
  .o_powerdown_or_irq_pin, .o_powerdown_or_irq_pin_oe, .o_powerdown_req);
